// ---- lsf_pkg.sv ----
package lsf_pkg;

    // ************************************************************
    // Display RAM geometry
    // ************************************************************
    localparam int unsigned RAM_DEPTH     = 35;
    localparam logic [5:0]  ADDR_FIRST    = 6'h00;
    localparam logic [5:0]  ADDR_LAST     = 6'h22;
    localparam int unsigned SEG_FIRST     = 4;
    localparam int unsigned SEG_COUNT     = 27;
    localparam int unsigned COM_COUNT     = 4;

    // ************************************************************
    // Serial byte layout
    // ************************************************************
    localparam logic [3:0]  BITS_NIBBLE   = 4'h4;
    localparam logic [3:0]  BITS_BYTE     = 4'h8;
    localparam int unsigned POS_CMD_FLAG  = 7;
    localparam int unsigned POS_MODE_ON   = 3;
    localparam int unsigned POS_MODE_BIAS = 2;
    localparam int unsigned POS_DIS_INV   = 2;
    localparam int unsigned POS_IC_MSB    = 2;
    localparam int unsigned POS_IC_RESET  = 1;
    localparam int unsigned POS_IC_CLK    = 0;

    typedef enum logic [2:0] {
        LSF_CMD_ADDR, LSF_CMD_DISPLAY_CONTROL_CMD, LSF_CMD_MODE, LSF_CMD_ICOP,
        LSF_CMD_BLINK, LSF_CMD_OTHER
    } lsf_cmd_e;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0]  OFS_STATUS    = 8'h00;
    localparam logic [7:0]  OFS_CONFIG    = 8'h04;
    localparam logic [7:0]  OFS_RAM_BASE  = 8'h40;
    localparam logic [7:0]  OFS_RAM_LAST  = 8'hC8;
    localparam logic        RST_OUT_EN    = 1'b1;
    localparam logic [1:0]  RST_FRAME     = 2'h0;
    localparam logic [1:0]  RST_POWER     = 2'h2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned PHASE_TIME_NS = 3125000;
    localparam int unsigned PHASE_CYCLES  = PHASE_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  EXT_DIV_LAST  = 8'h7F;
    localparam logic [8:0]  BLINK_HALF_05 = 9'h13F;
    localparam logic [8:0]  BLINK_HALF_1  = 9'h09F;
    localparam logic [8:0]  BLINK_HALF_2  = 9'h04F;

endpackage : lsf_pkg

// ---- lsf_serial_front_end.sv ----
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - Select high holds bit counter at start
// - Bytes arrive MSB first, flag bit leading
// - Sample on shift rise, word on eighth fall
// - First byte after select falls is command
// - Flag one: next command; zero: display data
// - Data mode persists until select rises
// - Partial commands discarded when select rises
// - Display RAM of four-bit words
// - Columns 0-3 and 31-34 are dummy writable
// - Two nibbles per byte, address auto-increments
// - Address wraps from 22h to 00h
// - Partial nibble never written
// - Logic timing from internal or external clock
// - Software reset: display off, address cleared
// - Inhibit low forces display off
// - Four commons, 27 segments, quarter duty
// - Bias and inversion selectable by command
// - Blink rate counted in phase steps, not frames
// - Address command with MSB; invalid gives 00h
// - Reset bit and clock select bit
// - Display on bit and bias bit
module lsf_serial_front_end
    import lsf_pkg::*;
#(
    parameter int unsigned PHASE_COUNT = PHASE_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 clk_en,
    // Serial link
    input  wire logic                 serial_select_n,
    input  wire logic                 serial_shift_clock,
    input  wire logic                 serial_data_in,
    // Pins
    input  wire logic                 display_inhibit_n,
    input  wire logic                 external_clock_in,
    // LCD drive
    output logic [COM_COUNT-1:0]      common_output,
    output logic [SEG_COUNT-1:0]      segment_output,
    output logic                      drive_polarity,
    output logic                      bias_half,
    output logic                      display_active,
    // Avalon-MM slave
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest
);
    default clocking cb_main @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ************************************************************
    // Decoding helpers
    // ************************************************************
    function automatic lsf_cmd_e cmd_kind(input logic [7:0] b);
        lsf_cmd_e k;
        k = LSF_CMD_OTHER;
        case (b[6:5])
            2'b00: k = LSF_CMD_ADDR;
            2'b01: k = LSF_CMD_DISPLAY_CONTROL_CMD;
            2'b10: k = LSF_CMD_MODE;
            2'b11: begin
                if (b[4:3] == 2'b01) k = LSF_CMD_ICOP;
                else if (b[4:3] == 2'b10) k = LSF_CMD_BLINK;
                else k = LSF_CMD_OTHER;
            end
            default: k = LSF_CMD_OTHER;
        endcase
        return k;
    endfunction : cmd_kind

    function automatic logic [5:0] addr_next(input logic [5:0] a);
        return (a >= ADDR_LAST) ? ADDR_FIRST : a + 6'h01;
    endfunction : addr_next

    // ************************************************************
    // State
    // ************************************************************
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic        sclk_prev_reg;
    logic        data_mode_reg;
    logic [5:0]  addr_reg;
    logic        addr_msb_reg;
    logic        mode_on_reg;
    logic        bias_reg;
    logic        frame_inv_reg;
    logic [1:0]  frame_rate_reg;
    logic [1:0]  power_reg;
    logic        ext_clk_sel_reg;
    logic [1:0]  blink_reg;
    logic [3:0]  display_ram [RAM_DEPTH];
    logic        out_en_reg;
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic        ext_prev_reg;
    logic [19:0] int_div_reg;
    logic [7:0]  ext_div_reg;
    logic [1:0]  phase_reg;
    logic        polarity_reg;
    logic [8:0]  blink_cnt_reg;
    logic        blink_off_reg;
    logic [COM_COUNT-1:0] com_reg;
    logic [SEG_COUNT-1:0] seg_reg;
    logic        active_reg;

    // ************************************************************
    // Serial receive decode
    // ************************************************************
    wire        sel_active  = ~serial_select_n;
    wire        sclk_rise   = sel_active & serial_shift_clock & ~sclk_prev_reg;
    wire        sclk_fall   = sel_active & ~serial_shift_clock & sclk_prev_reg;
    wire        byte_done   = sclk_fall & (bit_cnt_reg == BITS_BYTE);
    wire        nibble_done = sclk_fall & data_mode_reg
                              & ((bit_cnt_reg == BITS_NIBBLE) | byte_done);
    wire        cmd_done    = byte_done & ~data_mode_reg;
    lsf_cmd_e   cmd_k;
    assign cmd_k = cmd_kind(shift_reg);
    wire        soft_reset  = cmd_done & (cmd_k == LSF_CMD_ICOP)
                              & shift_reg[POS_IC_RESET];
    wire [5:0]  addr_req    = {addr_msb_reg, shift_reg[4:0]};
    wire        addr_load   = cmd_done & (cmd_k == LSF_CMD_ADDR) & ~soft_reset;

    // Bit counter and shifter; select high clears the bit count, so any partial byte is dropped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 8'h00;
            sclk_prev_reg <= 1'b0;
        end else if (clk_en) begin
            sclk_prev_reg <= serial_shift_clock;
            if (!sel_active) begin
                bit_cnt_reg <= 4'h0;
            end else if (sclk_rise) begin
                shift_reg   <= {shift_reg[6:0], serial_data_in};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (byte_done) begin
                bit_cnt_reg <= 4'h0;
            end
        end
    end

    // Command / data mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_mode_reg <= 1'b0;
        end else if (clk_en) begin
            if (!sel_active) begin
                data_mode_reg <= 1'b0;
            end else if (cmd_done && !shift_reg[POS_CMD_FLAG]) begin
                data_mode_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Command registers
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_on_reg     <= 1'b0;
            bias_reg        <= 1'b0;
            frame_inv_reg   <= 1'b0;
            frame_rate_reg  <= RST_FRAME;
            power_reg       <= RST_POWER;
            ext_clk_sel_reg <= 1'b0;
            blink_reg       <= 2'h0;
            addr_msb_reg    <= 1'b0;
        end else if (clk_en) begin
            if (soft_reset) begin
                mode_on_reg     <= 1'b0;
                bias_reg        <= 1'b0;
                frame_inv_reg   <= 1'b0;
                frame_rate_reg  <= RST_FRAME;
                power_reg       <= RST_POWER;
                ext_clk_sel_reg <= 1'b0;
                blink_reg       <= 2'h0;
                addr_msb_reg    <= 1'b0;
            end else if (cmd_done) begin
                case (cmd_k)
                    LSF_CMD_MODE: begin
                        mode_on_reg <= shift_reg[POS_MODE_ON];
                        bias_reg    <= shift_reg[POS_MODE_BIAS];
                    end
                    LSF_CMD_DISPLAY_CONTROL_CMD: begin
                        frame_rate_reg <= shift_reg[4:3];
                        frame_inv_reg  <= shift_reg[POS_DIS_INV];
                        power_reg      <= shift_reg[1:0];
                    end
                    LSF_CMD_ICOP: begin
                        addr_msb_reg    <= shift_reg[POS_IC_MSB];
                        ext_clk_sel_reg <= shift_reg[POS_IC_CLK];
                    end
                    LSF_CMD_BLINK: blink_reg <= shift_reg[1:0];
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // Display RAM write path
    // ************************************************************
    // Address register only moves on whole nibbles or a whole command
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_reg <= ADDR_FIRST;
        end else if (clk_en) begin
            if (soft_reset) begin
                addr_reg <= ADDR_FIRST;
            end else if (addr_load) begin
                addr_reg <= (addr_req > ADDR_LAST) ? ADDR_FIRST : addr_req;
            end else if (nibble_done) begin
                addr_reg <= addr_next(addr_reg);
            end
        end
    end

    // Contents survive reset; dummy columns are stored like any other
    always_ff @(posedge clk) begin
        if (clk_en && nibble_done) begin
            display_ram[addr_reg] <= shift_reg[3:0];
        end
    end

    // ************************************************************
    // Frame timing
    // ************************************************************
    wire ext_rise    = external_clock_in & ~ext_prev_reg;
    wire int_step    = (int_div_reg == 20'(PHASE_COUNT - 1));
    wire ext_step    = ext_rise & (ext_div_reg == EXT_DIV_LAST);
    wire phase_step  = ext_clk_sel_reg ? ext_step : int_step;
    wire frame_step  = phase_step & (phase_reg == 2'h3);
    wire [8:0] blink_half = (blink_reg == 2'h1) ? BLINK_HALF_05 :
                            (blink_reg == 2'h2) ? BLINK_HALF_1 : BLINK_HALF_2;
    wire blink_wrap  = (blink_cnt_reg == blink_half);
    wire show        = mode_on_reg & display_inhibit_n & out_en_reg
                       & ~blink_off_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_prev_reg <= 1'b0;
            int_div_reg  <= 20'h00000;
            ext_div_reg  <= 8'h00;
        end else if (clk_en) begin
            ext_prev_reg <= external_clock_in;
            int_div_reg  <= int_step ? 20'h00000 : int_div_reg + 20'h00001;
            if (ext_rise) begin
                ext_div_reg <= (ext_div_reg == EXT_DIV_LAST) ? 8'h00 : ext_div_reg + 8'h01;
            end
        end
    end

    // Phase, inversion polarity and blink state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg     <= 2'h0;
            polarity_reg  <= 1'b0;
            blink_cnt_reg <= 9'h000;
            blink_off_reg <= 1'b0;
        end else if (clk_en && phase_step) begin
            phase_reg <= phase_reg + 2'h1;
            if (!frame_inv_reg || frame_step) begin
                polarity_reg <= ~polarity_reg;
            end
            if (blink_reg == 2'h0) begin
                blink_cnt_reg <= 9'h000;
                blink_off_reg <= 1'b0;
            end else if (blink_wrap) begin
                blink_cnt_reg <= 9'h000;
                blink_off_reg <= ~blink_off_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 9'h001;
            end
        end
    end

    // ************************************************************
    // LCD outputs
    // ************************************************************
    logic [SEG_COUNT-1:0] seg_next;
    genvar gi;
    generate
        for (gi = 0; gi < SEG_COUNT; gi++) begin : g_seg
            assign seg_next[gi] = show & display_ram[gi + SEG_FIRST][phase_reg];
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            com_reg    <= '0;
            seg_reg    <= '0;
            active_reg <= 1'b0;
        end else if (clk_en) begin
            com_reg    <= show ? (4'h1 << phase_reg) : 4'h0;
            seg_reg    <= seg_next;
            active_reg <= show;
        end
    end

    assign common_output  = com_reg;
    assign segment_output = seg_reg;
    assign drive_polarity = polarity_reg;
    assign bias_half      = bias_reg;
    assign display_active = active_reg;

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************
    // One wait cycle; writes land on the edge waitrequest is seen low
    wire        bus_req   = (avs_read | avs_write) & wait_reg;
    wire        ram_hit   = (avs_address >= OFS_RAM_BASE) & (avs_address <= OFS_RAM_LAST)
                            & (avs_address[1:0] == 2'h0);
    wire [7:0]  ram_byte  = avs_address - OFS_RAM_BASE;
    wire [5:0]  ram_idx   = ram_byte[7:2];
    wire [31:0] status_w  = {12'h000, blink_reg, power_reg, frame_rate_reg,
                             ext_clk_sel_reg, frame_inv_reg, bias_reg, mode_on_reg,
                             active_reg, data_mode_reg, addr_msb_reg, addr_reg, 1'b0};
    wire [31:0] rd_mux    = (avs_address == OFS_STATUS) ? status_w :
                            (avs_address == OFS_CONFIG) ? {31'h0, out_en_reg} :
                            ram_hit ? {28'h0, display_ram[ram_idx]} : 32'h0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_reg   <= 1'b1;
            rdata_reg  <= 32'h00000000;
            out_en_reg <= RST_OUT_EN;
        end else if (clk_en) begin
            wait_reg <= ~bus_req;
            if (bus_req && avs_read) begin
                rdata_reg <= rd_mux;
            end
            if (!wait_reg && avs_write && avs_address == OFS_CONFIG && avs_byteenable[0]) begin
                out_en_reg <= avs_writedata[0];
            end
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_idle_cnt;
        (clk_en && serial_select_n) |=> (bit_cnt_reg == 4'h0);
    endproperty
    a_idle_cnt: assert property (p_idle_cnt) else $error("bit count not held");
    property p_first_cmd;
        (clk_en && serial_select_n) |=> !data_mode_reg;
    endproperty
    a_first_cmd: assert property (p_first_cmd) else $error("data mode after deselect");
    property p_enter_data;
        (clk_en && cmd_done && !shift_reg[7]) |=> data_mode_reg;
    endproperty
    a_enter_data: assert property (p_enter_data) else $error("data mode not entered");
    property p_stay_data;
        (data_mode_reg && !serial_select_n) |=> data_mode_reg;
    endproperty
    a_stay_data: assert property (p_stay_data) else $error("data mode left early");
    property p_wrap;
        (clk_en && nibble_done && !soft_reset && addr_reg == 6'h22) |=> addr_reg == 6'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("address did not wrap");
    property p_incr;
        (clk_en && nibble_done && !soft_reset && addr_reg < 6'h22)
            |=> addr_reg == $past(addr_reg) + 6'h01;
    endproperty
    a_incr: assert property (p_incr) else $error("address did not step");
    property p_partial;
        (clk_en && serial_select_n) |=> $stable(addr_reg) || $past(soft_reset);
    endproperty
    a_partial: assert property (p_partial) else $error("address moved while deselected");
    property p_sw_reset;
        (clk_en && soft_reset) |=> (addr_reg == 6'h00 && !mode_on_reg) ##1 !active_reg;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("software reset incomplete");
    property p_inhibit;
        (clk_en && !display_inhibit_n) |=> (!active_reg && common_output == 4'h0);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("display on while inhibited");
    property p_addr_range;
        addr_reg <= 6'h22;
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("address out of range");
    property p_bus_answer;
        (clk_en && (avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus not answered");
endmodule : lsf_serial_front_end

// ---- lsf_host_model.sv ----
`timescale 1ns/1ns
module lsf_host_model (
    // Clock
    input  wire logic clk,
    // Serial link
    output logic      serial_select_n,
    output logic      serial_shift_clock,
    output logic      serial_data_in
);

    initial begin
        serial_select_n    = 1'b1;
        serial_shift_clock = 1'b0;
        serial_data_in     = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    task automatic frame_open();
        serial_select_n <= 1'b0;
        wait_clk(3);
    endtask : frame_open

    // Data line toggles after release so a stale level is never mistaken for a bit
    task automatic frame_close();
        serial_select_n <= 1'b1;
        serial_data_in  <= ~serial_data_in;
        wait_clk(4);
    endtask : frame_close

    // Shift clock high lasts three cycles and low lasts six, above the one cycle per level the block needs
    task automatic send_bits(input logic [7:0] value, input int count);
        for (int i = 7; i > 7 - count; i--) begin
            serial_data_in <= value[i];
            wait_clk(3);
            serial_shift_clock <= 1'b1;
            wait_clk(3);
            serial_shift_clock <= 1'b0;
            wait_clk(3);
        end
    endtask : send_bits

endmodule : lsf_host_model

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    import lsf_pkg::*;

    logic        clk;
    logic        arst_n;
    logic        display_inhibit_n;
    logic        external_clock_in;
    logic [1:0]  ext_cnt;
    logic        bias_half;
    logic        display_active;
    logic [3:0]  common_output;
    logic [26:0] segment_output;
    logic        drive_polarity;
    logic        pol;
    logic        serial_select_n;
    logic        serial_shift_clock;
    logic        serial_data_in;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] rdata;
    int          num_errors;
    int          num_checks;
    localparam logic [55:0] WRAP_SEQ = 56'hEACCEC005A3CF1;

    lsf_serial_front_end #(.PHASE_COUNT(8)) lsf_serial_front_end_inst (
        .clk(clk), .arst_n(arst_n), .clk_en(1'b1),
        .serial_select_n(serial_select_n), .serial_shift_clock(serial_shift_clock),
        .serial_data_in(serial_data_in), .display_inhibit_n(display_inhibit_n),
        .external_clock_in(external_clock_in), .common_output(common_output),
        .segment_output(segment_output), .drive_polarity(drive_polarity),
        .bias_half(bias_half), .display_active(display_active),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    lsf_host_model host_inst (
        .clk(clk), .serial_select_n(serial_select_n),
        .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Slow external frame clock, four cycles per level
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_cnt           <= 2'h0;
            external_clock_in <= 1'b0;
        end else begin
            ext_cnt <= ext_cnt + 2'h1;
            if (ext_cnt == 2'h3) begin
                external_clock_in <= ~external_clock_in;
            end
        end
    end

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus_cycle(input logic [7:0] addr, input logic wr, input logic [31:0] wd);
        int n;
        @(posedge clk);
        avs_address   <= addr;
        avs_writedata <= wd;
        avs_read      <= ~wr;
        avs_write     <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            $display("unexpected at %0t: bus timeout", $time);
            print_verdict();
        end
    endtask : bus_cycle

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] mask,
                          input logic [31:0] exp);
        bus_cycle(addr, 1'b0, 32'h0);
        check(rdata & mask, exp);
    endtask : rd_chk

    task automatic ram_chk(input logic [5:0] idx, input logic [3:0] exp);
        rd_chk(OFS_RAM_BASE + {idx, 2'b00}, 32'hFFFFFFFF, {28'h0, exp});
    endtask : ram_chk

    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int n);
        host_inst.frame_open();
        host_inst.send_bits(b0, 8);
        if (n > 1) begin
            host_inst.send_bits(b1, 8);
        end
        host_inst.frame_close();
    endtask : frame

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        arst_n = 1'b0;
        display_inhibit_n = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        num_errors = 0;
        num_checks = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(OFS_STATUS, 32'hFFFFFFFF, 32'h00020000);
        rd_chk(OFS_CONFIG, 32'hFFFFFFFF, 32'h1);
        bus_cycle(OFS_CONFIG, 1'b1, 32'h0);
        rd_chk(OFS_CONFIG, 32'hFFFFFFFF, 32'h0);
        bus_cycle(8'h10, 1'b1, 32'hFFFFFFFF);
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h0);
        // Reset, display on with half bias, MSB set, address 20h, data across the wrap
        host_inst.frame_open();
        for (int i = 0; i < 7; i++) begin
            host_inst.send_bits(WRAP_SEQ[55 - 8 * i -: 8], 8);
        end
        host_inst.send_bits(8'hFF, 2);
        host_inst.frame_close();
        ram_chk(6'h20, 4'h5);
        ram_chk(6'h21, 4'hA);
        ram_chk(6'h22, 4'h3);
        ram_chk(6'h00, 4'hC);
        ram_chk(6'h01, 4'hF);
        ram_chk(6'h02, 4'h1);
        rd_chk(OFS_STATUS, 32'hFFFFFDFF, 32'h00020C86);
        check({31'h0, bias_half}, 32'h1);
        // Partial command is dropped; the whole one before it clears the MSB
        host_inst.frame_open();
        host_inst.send_bits(8'hE8, 8);
        host_inst.send_bits(8'hC0, 4);
        host_inst.frame_close();
        rd_chk(OFS_STATUS, 32'h00000480, 32'h00000400);
        bus_cycle(OFS_CONFIG, 1'b1, 32'h1);
        host_inst.wait_clk(2);
        check({31'h0, display_active}, 32'h1);
        display_inhibit_n <= 1'b0;
        host_inst.wait_clk(4);
        check({31'h0, display_active}, 32'h0);
        check({28'h0, common_output}, 32'h0);
        display_inhibit_n <= 1'b1;
        frame(8'h05, 8'h96, 2);
        ram_chk(6'h05, 4'h9);
        ram_chk(6'h06, 4'h6);
        rd_chk(OFS_STATUS, 32'h0000017E, 32'h0000000E);
        check({31'h0, $onehot(common_output)}, 32'h1);
        check({30'h0, segment_output[2:1]}, |(common_output & 4'h9) ? 32'h1 : 32'h2);
        pol = drive_polarity;
        host_inst.wait_clk(8);
        check({31'h0, drive_polarity}, {31'h0, ~pol});
        frame(8'hE9, 8'h00, 1);
        rd_chk(OFS_STATUS, 32'h00002000, 32'h00002000);
        frame(8'hEC, 8'h82, 2);
        rd_chk(OFS_STATUS, 32'h000000FF, 32'h000000C4);
        frame(8'hEC, 8'h9F, 2);
        rd_chk(OFS_STATUS, 32'h000000FF, 32'h00000080);
        frame(8'hEA, 8'h00, 1);
        rd_chk(OFS_STATUS, 32'hFFFFFDFF, 32'h00020000);
        ram_chk(6'h05, 4'h9);
        print_verdict();
    end

endmodule : tb_top
